// ==== core/timed_write_unlock.sv ====
// Timed write unlock gate for protected special registers
// Assumes CPU writes and machine-cycle tick arrive on clk, one cycle each
//
// Operation
// - Write-only unlock register, resets to zero
// - First key starts second-key watch counter
// - Second key up to the fourth machine-cycle tick opens
// - Late second key leaves window shut
// - Window closes itself on the fourth machine-cycle tick
// - Protected writes outside window are discarded
// - Several writes allowed, late ones dropped
// - Reads are never gated
// - Five protected registers at fixed addresses
`timescale 1ns/10ps
`include "unlock_map.svh"
`default_nettype none

module timed_write_unlock (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Machine-cycle tick from the CPU core
   input  wire logic             mc_tick,
   // Special register write from the CPU core
   input  wire unlock_pkg::sfr_wr_t cpu_wr,
   // Gated write toward the special registers
   output var  unlock_pkg::sfr_wr_t sfr_wr_r,
   output var  logic             wr_dropped_r,
   // Status
   output var  logic             key_pending_r,
   output var  logic             window_open_r
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   unlock_pkg::unlock_state_t state_r;
   unlock_pkg::unlock_state_t state_nxt;
   logic [1:0]                 cnt_r;
   logic [1:0]                 cnt_nxt;

   wire key_wr   = cpu_wr.en && (cpu_wr.addr == `UNLOCK_KEY_ADDR);
   wire first_wr = key_wr && (cpu_wr.data == `UNLOCK_KEY_FIRST);
   wire second_wr = key_wr && (cpu_wr.data == `UNLOCK_KEY_SECOND);

   wire prot_addr = (cpu_wr.addr == `CHIP_CONTROL_ADDR)
                 || (cpu_wr.addr == `FLASH_TRIGGER_ADDR)
                 || (cpu_wr.addr == `POWER_MONITOR_ADDR)
                 || (cpu_wr.addr == `OSC_TRIM_ADDR)
                 || (cpu_wr.addr == `WATCHDOG_CTRL_ADDR);
   wire prot_wr  = cpu_wr.en && prot_addr;
   wire is_open  = (state_r == unlock_pkg::ST_OPEN);
   wire expired  = mc_tick && (cnt_r == `UNLOCK_MC_ZERO);
   wire cnt_dec  = mc_tick && (cnt_r != `UNLOCK_MC_ZERO);

   wire pass_wr  = cpu_wr.en && !key_wr && (!prot_addr || is_open);
   wire drop_wr  = prot_wr && !is_open;

   ////////////////////////////////////////////////////////////////////////
   // Sequence state

   // Write in the same cycle as the expiring tick still counts as in time
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_dec ? cnt_r - `UNLOCK_MC_STEP : cnt_r;
      case (state_r)
         unlock_pkg::ST_IDLE: begin
            if (first_wr) begin
               state_nxt = unlock_pkg::ST_WAIT_KEY2;
               cnt_nxt   = `UNLOCK_MC_WINDOW;
            end
         end
         unlock_pkg::ST_WAIT_KEY2: begin
            if (second_wr) begin
               state_nxt = unlock_pkg::ST_OPEN;
               cnt_nxt   = `UNLOCK_MC_WINDOW;
            end else if (first_wr) begin
               cnt_nxt   = `UNLOCK_MC_WINDOW;
            end else if (key_wr) begin
               state_nxt = unlock_pkg::ST_IDLE;
            end else if (expired) begin
               state_nxt = unlock_pkg::ST_IDLE;
            end
         end
         unlock_pkg::ST_OPEN: begin
            if (first_wr) begin
               state_nxt = unlock_pkg::ST_WAIT_KEY2;
               cnt_nxt   = `UNLOCK_MC_WINDOW;
            end else if (expired) begin
               state_nxt = unlock_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = unlock_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= unlock_pkg::ST_IDLE;
         cnt_r   <= `UNLOCK_MC_ZERO;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // only writes pass this gate, reads bypass it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_wr_r      <= '0;
         wr_dropped_r  <= 1'b0;
         key_pending_r <= 1'b0;
         window_open_r <= 1'b0;
      end else begin
         sfr_wr_r.en   <= pass_wr;
         sfr_wr_r.addr <= cpu_wr.addr;
         sfr_wr_r.data <= cpu_wr.data;
         wr_dropped_r  <= drop_wr;
         key_pending_r <= (state_nxt == unlock_pkg::ST_WAIT_KEY2);
         window_open_r <= (state_nxt == unlock_pkg::ST_OPEN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_first_key_arms: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_r == unlock_pkg::ST_IDLE) && first_wr
      |=> key_pending_r && (cnt_r == `UNLOCK_MC_WINDOW))
      else $error("first key did not arm the counter");

   a_second_key_opens: assert property (
      @(posedge clk) disable iff (!arst_n)
      key_pending_r && second_wr |=> window_open_r && !key_pending_r)
      else $error("second key in time did not open window");

   a_late_key_shut: assert property (
      @(posedge clk) disable iff (!arst_n)
      key_pending_r && expired && !key_wr
      ##1 (cpu_wr.en && prot_addr) |=> !sfr_wr_r.en && wr_dropped_r)
      else $error("write after late key was not dropped");

   a_window_three_ticks: assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(window_open_r) |-> cnt_r == `UNLOCK_MC_WINDOW)
      else $error("window did not start with three ticks");

   a_window_closes: assert property (
      @(posedge clk) disable iff (!arst_n)
      window_open_r && expired && !first_wr |=> !window_open_r)
      else $error("window stayed open after expiry");

   a_closed_drop: assert property (
      @(posedge clk) disable iff (!arst_n)
      prot_wr && !window_open_r |=> !sfr_wr_r.en && wr_dropped_r)
      else $error("protected write passed while closed");

   a_open_pass: assert property (
      @(posedge clk) disable iff (!arst_n)
      prot_wr && window_open_r
      |=> sfr_wr_r.en && !wr_dropped_r
          && (sfr_wr_r.data == $past(cpu_wr.data)))
      else $error("protected write lost inside window");

   a_bad_key_cancel: assert property (
      @(posedge clk) disable iff (!arst_n)
      key_pending_r && key_wr && !first_wr && !second_wr
      |=> !key_pending_r && !window_open_r)
      else $error("wrong second key did not cancel");

   a_key_not_forwarded: assert property (
      @(posedge clk) disable iff (!arst_n)
      key_wr |=> !sfr_wr_r.en)
      else $error("unlock register write leaked to bus");

   a_plain_pass: assert property (
      @(posedge clk) disable iff (!arst_n)
      cpu_wr.en && !key_wr && !prot_addr
      |=> sfr_wr_r.en && !wr_dropped_r
          && (sfr_wr_r.addr == $past(cpu_wr.addr)))
      else $error("unprotected write was not forwarded");

   a_late_write_dropped: assert property (
      @(posedge clk) disable iff (!arst_n)
      window_open_r && expired && !first_wr
      ##1 prot_wr |=> !sfr_wr_r.en && wr_dropped_r)
      else $error("write after window close was forwarded");

   a_window_counts: assert property (
      @(posedge clk) disable iff (!arst_n)
      window_open_r && !first_wr && !expired |=> window_open_r)
      else $error("window closed before its ticks ran out");

   a_pending_expires: assert property (
      @(posedge clk) disable iff (!arst_n)
      key_pending_r && expired && !key_wr
      |=> !key_pending_r && !window_open_r)
      else $error("pending key outlived its ticks");

   a_restart_wait: assert property (
      @(posedge clk) disable iff (!arst_n)
      key_pending_r && first_wr
      |=> key_pending_r && (cnt_r == `UNLOCK_MC_WINDOW))
      else $error("repeated first key did not restart wait");

endmodule

`default_nettype wire

// ==== include/unlock_map.svh ====
// Constant map for the timed write unlock block
// Assumes an 8-bit special register address space
`ifndef UNLOCK_MAP_SVH
`define UNLOCK_MAP_SVH

`define UNLOCK_KEY_ADDR     8'hC7
`define UNLOCK_KEY_RESET    8'h00
`define UNLOCK_KEY_FIRST    8'hAA
`define UNLOCK_KEY_SECOND   8'h55

`define CHIP_CONTROL_ADDR   8'h9F
`define FLASH_TRIGGER_ADDR  8'hA4
`define POWER_MONITOR_ADDR  8'hAC
`define OSC_TRIM_ADDR       8'h97
`define WATCHDOG_CTRL_ADDR  8'hAA

`define UNLOCK_MC_WINDOW    2'h3
`define UNLOCK_MC_ZERO      2'h0
`define UNLOCK_MC_STEP      2'h1

`endif

// ==== include/unlock_pkg.sv ====
// Types shared by the timed write unlock block
// Assumes the special register bus of an 8-bit CPU core
package unlock_pkg;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } sfr_wr_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_KEY2,
      ST_OPEN
   } unlock_state_t;

endpackage

// ==== sim/cpu_core_model.sv ====
// CPU core model: special register writes and machine-cycle ticks
// Assumes the bench hands it at most one request per clock
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                arst_n,
   // Requests from the bench
   input  wire logic                tick_req,
   input  wire unlock_pkg::sfr_wr_t req,
   // Toward the block
   output var  unlock_pkg::sfr_wr_t cpu_wr,
   output var  logic                mc_tick
);
   logic [15:0] last_r;
   // Idle bus shows inverted history, so the last value comes back on every second idle cycle
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) last_r <= 16'h0000;
      else last_r <= cpu_wr[15:0];
   assign cpu_wr  = req.en ? req : {1'b0, ~last_r};
   assign mc_tick = tick_req;
endmodule
`default_nettype wire

// ==== sim/timed_write_unlock_bench.sv ====
// Bench for the timed write unlock gate
// Assumes one row per clock, outputs checked one clock later
`timescale 1ns/10ps
`default_nettype none
module timed_write_unlock_bench;
   typedef struct packed {
      unlock_pkg::sfr_wr_t w;
      logic                t;
      logic [3:0]          e;
   } row_t;
   // Flags: forward, dropped, pending, open
   localparam row_t T2 = {17'h0_0000, 1'b1, 4'h2};
   localparam row_t T1 = {17'h0_0000, 1'b1, 4'h1};
   localparam int N = 39;
   row_t rows [N] = '{
      {17'h1_9F11,1'b0,4'h4}, {17'h1_4022,1'b0,4'h8}, {17'h1_C755,1'b0,4'h0},
      {17'h1_C7AA,1'b0,4'h2}, T2, T2, T2, {17'h1_C755,1'b0,4'h1},
      {17'h1_9F33,1'b0,4'h9}, {17'h1_A444,1'b1,4'h9}, T1,
      {17'h1_AC55,1'b1,4'h9}, {17'h1_9766,1'b0,4'h9}, {17'h1_AA77,1'b1,4'h8},
      {17'h1_9788,1'b0,4'h4}, {17'h1_C7AA,1'b0,4'h2}, T2, T2, T2,
      {17'h0_0000,1'b1,4'h0}, {17'h1_A4BB,1'b0,4'h4}, {17'h1_C755,1'b0,4'h0},
      {17'h1_9F99,1'b0,4'h4}, {17'h1_C7AA,1'b0,4'h2}, {17'h1_C712,1'b0,4'h0},
      {17'h1_C755,1'b0,4'h0}, {17'h1_AA01,1'b0,4'h4}, {17'h1_C7AA,1'b0,4'h2},
      {17'h1_C755,1'b0,4'h1}, {17'h1_C7AA,1'b0,4'h2}, {17'h1_9F02,1'b0,4'h6},
      T2, T2, T2, {17'h1_C7AA,1'b0,4'h2}, T2, T2, T2, {17'h1_C755,1'b0,4'h1}};
   logic                clk;
   logic                arst_n;
   logic                tick_req;
   unlock_pkg::sfr_wr_t req;
   unlock_pkg::sfr_wr_t cpu_wr;
   unlock_pkg::sfr_wr_t sfr_wr_r;
   logic                mc_tick;
   logic                wr_dropped_r;
   logic                key_pending_r;
   logic                window_open_r;
   int                  err_total = 0;
   int                  compares = 0;
   wire logic [3:0]     flags = {sfr_wr_r.en, wr_dropped_r,
                                 key_pending_r, window_open_r};
   cpu_core_model i_cpu_core_model (.clk(clk), .arst_n(arst_n),
      .tick_req(tick_req), .req(req), .cpu_wr(cpu_wr), .mc_tick(mc_tick));
   timed_write_unlock i_timed_write_unlock (.clk(clk), .arst_n(arst_n),
      .mc_tick(mc_tick), .cpu_wr(cpu_wr), .sfr_wr_r(sfr_wr_r),
      .wr_dropped_r(wr_dropped_r), .key_pending_r(key_pending_r),
      .window_open_r(window_open_r));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic drive(input logic [16:0] w);
      @(posedge clk);
      req <= w;
      @(posedge clk);
      req <= 17'h0_0000;
   endtask
   task automatic summarize;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      arst_n = 1'b0;
      tick_req = 1'b0;
      req = 17'h0_0000;
      repeat (12) @(posedge clk);
      chk({13'h0000, flags}, 17'h0_0000);
      arst_n <= 1'b1;
      for (int i = 0; i <= N; i++) begin
         @(posedge clk);
         req <= (i < N) ? rows[i].w : 17'h0_0000;
         tick_req <= (i < N) ? rows[i].t : 1'b0;
         #1;
         if (i > 0) begin
            chk({13'h0000, flags}, {13'h0000, rows[i-1].e});
            if (rows[i-1].e[3]) chk(sfr_wr_r, rows[i-1].w);
         end
      end
      // Reset in mid-window shuts it
      drive(17'h1_C7AA);
      drive(17'h1_C755);
      #1 chk({13'h0000, flags}, 17'h0_0001);
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      #1 chk({13'h0000, flags}, 17'h0_0000);
      drive(17'h1_9F5A);
      #1 chk({13'h0000, flags}, 17'h0_0004);
      summarize();
   end
endmodule
`default_nettype wire
